/* rtl/pdn_defs.svh */
// Purpose: offsets, field positions and reset values of the dma unit
// Assumes: byte addresses on a 32-bit wishbone bus
// Notes:   definitions only
`ifndef PDN_DEFS_SVH
`define PDN_DEFS_SVH
`define PDN_OFF_RX_NEXT_ADDR   6'h10
`define PDN_OFF_RX_NEXT_SIZE   6'h14
`define PDN_OFF_TX_NEXT_ADDR   6'h18
`define PDN_OFF_TX_NEXT_SIZE   6'h1c
`define PDN_OFF_REQ_CONTROL    6'h20
`define PDN_OFF_REQ_STATE      6'h24
`define PDN_OFF_RX_CUR_ADDR    6'h00
`define PDN_OFF_RX_CUR_SIZE    6'h04
`define PDN_OFF_TX_CUR_ADDR    6'h08
`define PDN_OFF_TX_CUR_SIZE    6'h0c
`define PDN_OFF_CHAN_FLAGS     6'h28
`define PDN_BIT_RX_EN          0
`define PDN_BIT_RX_DIS         1
`define PDN_BIT_TX_EN          8
`define PDN_BIT_TX_DIS         9
`define PDN_BIT_RX_END         0
`define PDN_BIT_RX_FULL        1
`define PDN_BIT_TX_END         8
`define PDN_BIT_TX_EMPTY       9
`define PDN_RST_ADDR           32'h0000_0000
`define PDN_RST_SIZE           16'h0000
`endif

/* rtl/pdn_pkg.sv */
// Purpose: shared types of the dma unit
// Assumes: nothing
// Notes:   constants live in pdn_defs.svh
package pdn_pkg;
  typedef logic [31:0] pdn_addr_t;
  typedef logic [15:0] pdn_size_t;
  typedef enum logic [2:0] {
    PDN_CH_IDLE = 3'b001,
    PDN_CH_RUN  = 3'b010,
    PDN_CH_DONE = 3'b100
  } pdn_ch_state_t;
endpackage : pdn_pkg

/* rtl/pdn_channel.sv */
// Purpose: one channel's current/next pointer and counter pair
// Assumes: beat_i only while the channel runs; writes come from the bus
// Notes:   reload of next into current when current runs out
`timescale 1ns/1ps
`include "pdn_defs.svh"
module pdn_channel
  import pdn_pkg::*;
(
  // clock and reset
  input  wire logic      clk_i,
  input  wire logic      rst_i,
  // software writes
  input  wire logic      cur_addr_we_i,
  input  wire logic      cur_size_we_i,
  input  wire logic      nxt_addr_we_i,
  input  wire logic      nxt_size_we_i,
  input  wire pdn_addr_t wdata_addr_i,
  input  wire pdn_size_t wdata_size_i,
  // transfer side
  input  wire logic      enable_i,
  input  wire logic      beat_i,
  // state
  output pdn_addr_t      cur_addr_o,
  output pdn_size_t      cur_size_o,
  output pdn_addr_t      nxt_addr_o,
  output pdn_size_t      nxt_size_o,
  output logic           active_o,
  output logic           end_o,
  output logic           buf_done_o
);
  pdn_addr_t     cur_addr_reg;
  pdn_size_t     cur_size_reg;
  pdn_addr_t     nxt_addr_reg;
  pdn_size_t     nxt_size_reg;
  pdn_ch_state_t state_reg;
  logic          end_reg;
  logic          done_reg;
  logic          last_beat;

  assign last_beat = beat_i && (cur_size_reg == 16'h0001);

  // 32-bit pointers and 16-bit counters; reload on exhaustion
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_addr_reg <= `PDN_RST_ADDR;
      cur_size_reg <= `PDN_RST_SIZE;
      nxt_addr_reg <= `PDN_RST_ADDR;
      nxt_size_reg <= `PDN_RST_SIZE;
    end else if (last_beat && nxt_size_reg != 16'h0000) begin
      cur_addr_reg <= nxt_addr_reg;
      cur_size_reg <= nxt_size_reg;
      nxt_addr_reg <= `PDN_RST_ADDR;
      nxt_size_reg <= `PDN_RST_SIZE;
    end else begin
      if (cur_addr_we_i) cur_addr_reg <= wdata_addr_i;
      else if (beat_i) cur_addr_reg <= cur_addr_reg + 32'h0000_0001;
      if (cur_size_we_i) cur_size_reg <= wdata_size_i;
      else if (beat_i) cur_size_reg <= cur_size_reg - 16'h0001;
      if (nxt_addr_we_i) nxt_addr_reg <= wdata_addr_i;
      if (nxt_size_we_i) nxt_size_reg <= wdata_size_i;
    end
  end

  // run/stop state
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= PDN_CH_IDLE;
    end else begin
      case (state_reg)
        PDN_CH_IDLE: begin
          if (enable_i && cur_size_reg != 16'h0000) state_reg <= PDN_CH_RUN;
        end
        PDN_CH_RUN: begin
          if (!enable_i) state_reg <= PDN_CH_IDLE;
          else if (last_beat && nxt_size_reg == 16'h0000)
            state_reg <= PDN_CH_DONE;
        end
        PDN_CH_DONE: begin
          if (cur_size_we_i || nxt_size_we_i) state_reg <= PDN_CH_IDLE;
        end
        default: state_reg <= PDN_CH_IDLE;
      endcase
    end
  end

  // sticky end and buffer-done flags; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      end_reg  <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      if (last_beat) end_reg <= 1'b1;
      else if ((cur_size_we_i || nxt_size_we_i) && wdata_size_i != 16'h0000)
        end_reg <= 1'b0;
      if (last_beat && nxt_size_reg == 16'h0000) done_reg <= 1'b1;
      else if ((cur_size_we_i || nxt_size_we_i) && wdata_size_i != 16'h0000)
        done_reg <= 1'b0;
    end
  end

  assign cur_addr_o = cur_addr_reg;
  assign cur_size_o = cur_size_reg;
  assign nxt_addr_o = nxt_addr_reg;
  assign nxt_size_o = nxt_size_reg;
  assign active_o   = (state_reg == PDN_CH_RUN);
  assign end_o      = end_reg;
  assign buf_done_o = done_reg;
endmodule : pdn_channel

/* rtl/pdn_dma_unit.sv */
// Purpose: register side of a peripheral dma channel pair
// Assumes: classic wishbone slave, one clock, synchronous reset
// Notes:   half_duplex_i ties receive and transmit views together
`timescale 1ns/1ps
`include "pdn_defs.svh"
// Function
// - 32-bit read/write next receive buffer address register.
// - half duplex: next receive and transmit addresses are one value.
// - next receive size register, low 16 bits, upper bits reserved.
// - half duplex: next receive and transmit sizes are one value.
// - 32-bit read/write next transmit buffer address register.
// - next transmit size register, low 16 bits, upper bits reserved.
// - control bit 0 enables receive unless bit 1 also set; zeros ignored.
// - control bit 1 disables receive requests.
// - control bit 8 enables transmit requests.
// - control bit 9 disables transmit requests.
// - half duplex: enabling receive turns transmit off.
// - half duplex: transmit enable works only without receive enable set.
// - half duplex: receive disable also disables transmit.
// - half duplex: transmit disable also disables receive.
// - state bit 0 shows receive requests enabled.
// - state bit 8 shows transmit requests enabled.
// - current counter exhausted, next nonzero: reload current, clear next.
// - both counters exhausted: channel stops, buffer-done flag set.
// - each channel keeps current and next 16-bit counters.
module pdn_dma_unit
  import pdn_pkg::*;
(
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [5:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // configuration
  input  wire logic        half_duplex_i,
  // peripheral handshake
  input  wire logic        rx_beat_i,
  input  wire logic        tx_beat_i,
  output logic             rx_active_o,
  output logic             tx_active_o,
  output logic [31:0]      rx_addr_o,
  output logic [31:0]      tx_addr_o,
  output logic             rx_buf_done_o,
  output logic             tx_buf_done_o
);
  logic        rx_en_reg;
  logic        tx_en_reg;
  logic        ack_reg;
  logic        err_reg;
  logic [31:0] dat_reg;
  logic        req;
  logic        wr;
  logic        mapped;
  logic [31:0] wdat;
  logic [31:0] rdat;
  logic        ctl_wr;
  logic        rx_en_w;
  logic        rx_dis_w;
  logic        tx_en_w;
  logic        tx_dis_w;
  logic        hd;
  logic        rx_ca_we, rx_cs_we, rx_na_we, rx_ns_we;
  logic        tx_ca_we, tx_cs_we, tx_na_we, tx_ns_we;
  pdn_addr_t   rx_ca, rx_na, tx_ca, tx_na;
  pdn_size_t   rx_cs, rx_ns, tx_cs, tx_ns;
  logic        rx_end, tx_end, rx_done, tx_done;

  // byte-lane merge of write data over an old value
  function automatic logic [31:0] lane_merge(input logic [31:0] old,
                                             input logic [31:0] nw,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
    end
    return r;
  endfunction : lane_merge

  // true when the offset names a register of this block
  function automatic logic is_mapped(input logic [5:0] a);
    case (a)
      `PDN_OFF_RX_CUR_ADDR, `PDN_OFF_RX_CUR_SIZE,
      `PDN_OFF_TX_CUR_ADDR, `PDN_OFF_TX_CUR_SIZE,
      `PDN_OFF_RX_NEXT_ADDR, `PDN_OFF_RX_NEXT_SIZE,
      `PDN_OFF_TX_NEXT_ADDR, `PDN_OFF_TX_NEXT_SIZE,
      `PDN_OFF_REQ_CONTROL, `PDN_OFF_REQ_STATE,
      `PDN_OFF_CHAN_FLAGS: is_mapped = 1'b1;
      default: is_mapped = 1'b0;
    endcase
  endfunction : is_mapped

  assign hd     = half_duplex_i;
  assign req    = cyc_i && stb_i && !ack_reg && !err_reg;
  assign mapped = is_mapped(adr_i);
  assign wr     = req && we_i && mapped;

  // write data merged per register with its current contents
  always_comb begin
    case (adr_i)
      `PDN_OFF_RX_CUR_ADDR:  wdat = lane_merge(rx_ca, dat_i, sel_i);
      `PDN_OFF_TX_CUR_ADDR:  wdat = lane_merge(tx_ca, dat_i, sel_i);
      `PDN_OFF_RX_NEXT_ADDR: wdat = lane_merge(rx_na, dat_i, sel_i);
      `PDN_OFF_TX_NEXT_ADDR: wdat = lane_merge(tx_na, dat_i, sel_i);
      `PDN_OFF_RX_CUR_SIZE:  wdat = lane_merge({16'h0000, rx_cs}, dat_i, sel_i);
      `PDN_OFF_TX_CUR_SIZE:  wdat = lane_merge({16'h0000, tx_cs}, dat_i, sel_i);
      `PDN_OFF_RX_NEXT_SIZE: wdat = lane_merge({16'h0000, rx_ns}, dat_i, sel_i);
      `PDN_OFF_TX_NEXT_SIZE: wdat = lane_merge({16'h0000, tx_ns}, dat_i, sel_i);
      default:               wdat = lane_merge(32'h0000_0000, dat_i, sel_i);
    endcase
  end

  // in half duplex a write to either view lands in both channels
  always_comb begin
    rx_ca_we = wr && (adr_i == `PDN_OFF_RX_CUR_ADDR ||
                      (hd && adr_i == `PDN_OFF_TX_CUR_ADDR));
    tx_ca_we = wr && (adr_i == `PDN_OFF_TX_CUR_ADDR ||
                      (hd && adr_i == `PDN_OFF_RX_CUR_ADDR));
    rx_cs_we = wr && (adr_i == `PDN_OFF_RX_CUR_SIZE ||
                      (hd && adr_i == `PDN_OFF_TX_CUR_SIZE));
    tx_cs_we = wr && (adr_i == `PDN_OFF_TX_CUR_SIZE ||
                      (hd && adr_i == `PDN_OFF_RX_CUR_SIZE));
    rx_na_we = wr && (adr_i == `PDN_OFF_RX_NEXT_ADDR ||
                      (hd && adr_i == `PDN_OFF_TX_NEXT_ADDR));
    tx_na_we = wr && (adr_i == `PDN_OFF_TX_NEXT_ADDR ||
                      (hd && adr_i == `PDN_OFF_RX_NEXT_ADDR));
    rx_ns_we = wr && (adr_i == `PDN_OFF_RX_NEXT_SIZE ||
                      (hd && adr_i == `PDN_OFF_TX_NEXT_SIZE));
    tx_ns_we = wr && (adr_i == `PDN_OFF_TX_NEXT_SIZE ||
                      (hd && adr_i == `PDN_OFF_RX_NEXT_SIZE));
  end

  pdn_channel u_rx (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .cur_addr_we_i (rx_ca_we),
    .cur_size_we_i (rx_cs_we),
    .nxt_addr_we_i (rx_na_we),
    .nxt_size_we_i (rx_ns_we),
    .wdata_addr_i  (wdat),
    .wdata_size_i  (wdat[15:0]),
    .enable_i      (rx_en_reg),
    .beat_i        (rx_beat_i),
    .cur_addr_o    (rx_ca),
    .cur_size_o    (rx_cs),
    .nxt_addr_o    (rx_na),
    .nxt_size_o    (rx_ns),
    .active_o      (rx_active_o),
    .end_o         (rx_end),
    .buf_done_o    (rx_done)
  );

  pdn_channel u_tx (
    .clk_i         (clk_i),
    .rst_i         (rst_i),
    .cur_addr_we_i (tx_ca_we),
    .cur_size_we_i (tx_cs_we),
    .nxt_addr_we_i (tx_na_we),
    .nxt_size_we_i (tx_ns_we),
    .wdata_addr_i  (wdat),
    .wdata_size_i  (wdat[15:0]),
    .enable_i      (tx_en_reg),
    .beat_i        (tx_beat_i),
    .cur_addr_o    (tx_ca),
    .cur_size_o    (tx_cs),
    .nxt_addr_o    (tx_na),
    .nxt_size_o    (tx_ns),
    .active_o      (tx_active_o),
    .end_o         (tx_end),
    .buf_done_o    (tx_done)
  );

  // control strobes, only lanes actually selected count
  assign ctl_wr   = wr && (adr_i == `PDN_OFF_REQ_CONTROL);
  assign rx_en_w  = ctl_wr && sel_i[0] && dat_i[`PDN_BIT_RX_EN];
  assign rx_dis_w = ctl_wr && sel_i[0] && dat_i[`PDN_BIT_RX_DIS];
  assign tx_en_w  = ctl_wr && sel_i[1] && dat_i[`PDN_BIT_TX_EN];
  assign tx_dis_w = ctl_wr && sel_i[1] && dat_i[`PDN_BIT_TX_DIS];

  // receive request enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_en_reg <= 1'b0;
    end else if (rx_dis_w || (hd && tx_dis_w)) begin
      rx_en_reg <= 1'b0;
    end else if (rx_en_w) begin
      rx_en_reg <= 1'b1;
    end
  end

  // transmit request enable
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tx_en_reg <= 1'b0;
    end else if (tx_dis_w || (hd && rx_dis_w)) begin
      tx_en_reg <= 1'b0;
    end else if (hd && rx_en_w) begin
      tx_en_reg <= 1'b0;
    end else if (tx_en_w && !(hd && rx_en_reg)) begin
      tx_en_reg <= 1'b1;
    end
  end

  // read mux; reserved bits zero, control reads zero
  always_comb begin
    rdat = 32'h0000_0000;
    case (adr_i)
      `PDN_OFF_RX_CUR_ADDR:  rdat = rx_ca;
      `PDN_OFF_RX_CUR_SIZE:  rdat = {16'h0000, rx_cs};
      `PDN_OFF_TX_CUR_ADDR:  rdat = hd ? rx_ca : tx_ca;
      `PDN_OFF_TX_CUR_SIZE:  rdat = {16'h0000, hd ? rx_cs : tx_cs};
      `PDN_OFF_RX_NEXT_ADDR: rdat = rx_na;
      `PDN_OFF_RX_NEXT_SIZE: rdat = {16'h0000, rx_ns};
      `PDN_OFF_TX_NEXT_ADDR: rdat = hd ? rx_na : tx_na;
      `PDN_OFF_TX_NEXT_SIZE: rdat = {16'h0000, hd ? rx_ns : tx_ns};
      `PDN_OFF_REQ_STATE: begin
        rdat[`PDN_BIT_RX_EN] = rx_en_reg;
        rdat[`PDN_BIT_TX_EN] = tx_en_reg;
      end
      `PDN_OFF_CHAN_FLAGS: begin
        rdat[`PDN_BIT_RX_END]   = rx_end;
        rdat[`PDN_BIT_RX_FULL]  = rx_done;
        rdat[`PDN_BIT_TX_END]   = tx_end;
        rdat[`PDN_BIT_TX_EMPTY] = tx_done;
      end
      default: rdat = 32'h0000_0000;
    endcase
  end

  // one-cycle registered answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      err_reg <= 1'b0;
      dat_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= req && mapped;
      err_reg <= req && !mapped;
      if (req && mapped && !we_i) dat_reg <= rdat;
    end
  end

  assign dat_o         = dat_reg;
  assign ack_o         = ack_reg;
  assign err_o         = err_reg;
  assign rx_addr_o     = rx_ca;
  assign tx_addr_o     = tx_ca;
  assign rx_buf_done_o = rx_done;
  assign tx_buf_done_o = tx_done;
endmodule : pdn_dma_unit

/* tb/pdn_dma_unit_properties.sv */
// Purpose: bus and request-state properties of the dma unit
// Assumes: sees the top module's ports only
// Notes:   bound to pdn_dma_unit below
`timescale 1ns/1ps
module pdn_dma_unit_props (
  // watched ports
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [5:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        err_o,
  input wire logic        half_duplex_i,
  input wire logic        rx_active_o,
  input wire logic        tx_active_o,
  input wire logic [31:0] rx_addr_o,
  input wire logic        rx_buf_done_o
);
  logic req;
  logic ctl;
  logic rx_kill;
  logic tx_kill;
  assign req = cyc_i && stb_i && !ack_o && !err_o;
  assign ctl = req && we_i && adr_i == 6'h20;
  assign rx_kill = ctl && ((sel_i[0] && dat_i[1]) ||
                   (half_duplex_i && sel_i[1] && dat_i[9]));
  assign tx_kill = ctl && ((sel_i[1] && dat_i[9]) ||
                   (half_duplex_i && sel_i[0] && (dat_i[1] || dat_i[0])));
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_answer;
    req |=> ack_o != err_o;
  endproperty
  a_answer: assert property (p_answer)
    else $error("request not answered exactly once");
  property p_pulse;
    ack_o || err_o |=> !ack_o && !err_o;
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle");
  property p_spur;
    !(cyc_i && stb_i) |=> !ack_o && !err_o;
  endproperty
  a_spur: assert property (p_spur)
    else $error("answer without request");
  property p_unmapped;
    req && adr_i > 6'h2b |=> err_o;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped address not refused");
  property p_rx_off;
    rx_kill |-> ##[1:2] !rx_active_o;
  endproperty
  a_rx_off: assert property (p_rx_off)
    else $error("receive still active after disable");
  property p_tx_off;
    tx_kill |-> ##[1:2] !tx_active_o;
  endproperty
  a_tx_off: assert property (p_tx_off)
    else $error("transmit still active after disable");
  property p_hold;
    !(ack_o && !we_i) |-> $stable(dat_o);
  endproperty
  a_hold: assert property (p_hold)
    else $error("read data changed outside a read");
  property p_done;
    rx_buf_done_o && !(cyc_i && stb_i && we_i) |=> rx_buf_done_o;
  endproperty
  a_done: assert property (p_done)
    else $error("buffer-done dropped without a write");
  property p_reset;
    disable iff (1'b0)
    rst_i |=> !ack_o && !err_o && !rx_active_o && !tx_active_o &&
              rx_addr_o == 32'h0 && !rx_buf_done_o;
  endproperty
  a_reset: assert property (p_reset)
    else $error("outputs not cleared by reset");
endmodule : pdn_dma_unit_props

bind pdn_dma_unit pdn_dma_unit_props i_pdn_dma_unit_props (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
  .ack_o, .err_o, .half_duplex_i, .rx_active_o, .tx_active_o, .rx_addr_o,
  .rx_buf_done_o
);

/* tb/pdn_periph_model.sv */
// Purpose: serial peripheral side, moves one item per ready cycle
// Assumes: beats only while the channel runs
// Notes:   slow mode paces at one beat in four cycles
`timescale 1ns/1ps
module pdn_periph_model (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // pacing and channel state
  input  wire logic slow_i,
  input  wire logic rx_active_i,
  input  wire logic tx_active_i,
  // data moved
  output logic      rx_beat_o,
  output logic      tx_beat_o
);
  logic [1:0] pace_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) pace_reg <= 2'h0;
    else pace_reg <= pace_reg + 2'h1;
  end
  assign rx_beat_o = rx_active_i && (!slow_i || pace_reg == 2'h0);
  assign tx_beat_o = tx_active_i && (!slow_i || pace_reg == 2'h2);
endmodule : pdn_periph_model

/* tb/test_pdn_dma_unit.sv */
// Purpose: self-checking bench of the dma unit register side
// Assumes: one clock, synchronous reset, wishbone master tasks
// Notes:   random data from a fixed seed
`timescale 1ns/1ps
module test_pdn_dma_unit;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic        half_duplex_i = 1'b0;
  logic        slow = 1'b0;
  logic [5:0]  adr_i = 6'h0;
  logic [3:0]  sel_i = 4'h0;
  logic [3:0]  lanes = 4'hf;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rx_addr_o, tx_addr_o, q;
  logic        ack_o, err_o, rx_beat, tx_beat, e;
  logic        rx_active_o, tx_active_o, rx_buf_done_o, tx_buf_done_o;
  int          err_total = 0;
  int          checks_done = 0;
  int          rx_cnt = 0;
  int          tx_cnt = 0;

  always #12.5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    if (rx_beat) rx_cnt++;
    if (tx_beat) tx_cnt++;
  end

  pdn_dma_unit i_pdn_dma_unit (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .err_o, .half_duplex_i, .rx_beat_i(rx_beat), .tx_beat_i(tx_beat),
    .rx_active_o, .tx_active_o, .rx_addr_o, .tx_addr_o, .rx_buf_done_o,
    .tx_buf_done_o);
  pdn_periph_model i_pdn_periph_model (
    .clk_i, .rst_i, .slow_i(slow), .rx_active_i(rx_active_o),
    .tx_active_i(tx_active_o), .rx_beat_o(rx_beat), .tx_beat_o(tx_beat));

  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string what, input logic [31:0] exp, got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= lanes;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && err_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      report_and_stop();
    end
    q = dat_o;
    e = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask : bus

  task automatic rd(input string what, input logic [5:0] a,
                    input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, q);
  endtask : rd

  // b: rx en, rx dis, tx en, tx dis; result {tx, rx}
  function automatic logic [1:0] ctl_next(input logic h,
      input logic [1:0] c, input logic [3:0] b);
    logic [1:0] n;
    n = c;
    if (!h) begin
      if (b[0]) n[0] = 1'b1;
      if (b[1]) n[0] = 1'b0;
      if (b[2]) n[1] = 1'b1;
      if (b[3]) n[1] = 1'b0;
    end else if (b[1] || b[3]) n = 2'b00;
    else if (b[0]) n = 2'b01;
    else if (b[2] && !c[0]) n = 2'b10;
    return n;
  endfunction : ctl_next

  initial begin
    #(25 * 20000);
    err_total++;
    report_and_stop();
  end

  initial begin
    logic [31:0] v, w, s;
    logic [1:0]  p;
    logic [3:0]  b;
    void'($urandom(32'ha099));
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 'h10; a <= 'h24; a += 4) rd("reset", 6'(a), 32'h0);
    repeat (6) begin
      v = $urandom();
      w = $urandom();
      bus(1'b1, 6'h10, v);
      bus(1'b1, 6'h14, w);
      bus(1'b1, 6'h18, ~v);
      bus(1'b1, 6'h1c, ~w);
      rd("rx addr", 6'h10, v);
      rd("rx size", 6'h14, {16'h0, w[15:0]});
      rd("tx addr", 6'h18, ~v);
      rd("tx size", 6'h1c, {16'h0, ~w[15:0]});
    end
    // low two lanes only: upper half keeps the old value
    lanes = 4'h3;
    bus(1'b1, 6'h18, w);
    lanes = 4'hf;
    rd("tx addr lanes", 6'h18, {~v[31:16], w[15:0]});
    half_duplex_i <= 1'b1;
    v = $urandom();
    bus(1'b1, 6'h10, v);
    rd("shared addr", 6'h18, v);
    bus(1'b1, 6'h1c, v);
    rd("shared size", 6'h14, {16'h0, v[15:0]});
    for (int i = 0; i < 64; i++) begin
      b = 4'(i);
      // both enables at once is illegal in half duplex
      if (i[5] && b[0] && b[2]) continue;
      half_duplex_i <= i[5];
      p = 2'($urandom_range(i[5] ? 2 : 3, 0));
      bus(1'b1, 6'h20, 32'h202);
      bus(1'b1, 6'h20, {23'h0, p[1], 7'h0, p[0]});
      rd("state", 6'h24, {23'h0, p[1], 7'h0, p[0]});
      bus(1'b1, 6'h20, {22'h0, b[3:2], 6'h0, b[1:0]});
      p = ctl_next(i[5], p, b);
      s = {23'h0, p[1], 7'h0, p[0]};
      if (i[5]) rd("hd", 6'h24, s);
      else rd("fd", 6'h24, s);
    end
    rd("control", 6'h20, 32'h0);
    bus(1'b0, 6'h30, 32'h0);
    chk("unmapped", 32'h1, {31'h0, e});
    half_duplex_i <= 1'b0;
    bus(1'b1, 6'h20, 32'h202);
    for (int ch = 0; ch < 2; ch++) begin
      slow <= ch[0];
      v = $urandom_range(5, 2);
      w = $urandom_range(6, 1);
      s = $urandom();
      rx_cnt = 0;
      tx_cnt = 0;
      bus(1'b1, 6'(8 * ch + 'h10), s);
      bus(1'b1, 6'(8 * ch + 'h14), w);
      bus(1'b1, 6'(8 * ch + 4), v);
      bus(1'b1, 6'h20, ch ? 32'h100 : 32'h1);
      for (int t = 0; t < 400; t++) begin
        @(negedge clk_i);
        if (ch ? tx_buf_done_o : rx_buf_done_o) break;
      end
      chk("beats", v + w, ch ? tx_cnt : rx_cnt);
      chk("done", 32'h1, {31'h0, ch ? tx_buf_done_o : rx_buf_done_o});
      chk("cur addr", s + w, ch ? tx_addr_o : rx_addr_o);
      chk("stopped", 32'h0, {31'h0, ch ? tx_active_o : rx_active_o});
      rd("cur size", 6'(8 * ch + 4), 32'h0);
      rd("next size", 6'(8 * ch + 'h14), 32'h0);
    end
    report_and_stop();
  end
endmodule : test_pdn_dma_unit
